// ### include/adc_link_if.sv
// Two-wire link between the read controller and the converter.
// Assumes one controller, which alone drives the clock line.
`timescale 1ns/1ps
interface adc_link_if;
    logic scl;
    logic sda_host_o;
    logic sda_host_oe;
    logic sda_dev_o;
    logic sda_dev_oe;
    logic sda_line;

    // Open-drain data line: low while any end enables its driver
    assign sda_line = !((sda_host_oe && !sda_host_o) ||
                        (sda_dev_oe && !sda_dev_o));

    modport dev (
        input scl,
        input sda_line,
        output sda_dev_o,
        output sda_dev_oe
    );

    modport host (
        output scl,
        input sda_line,
        output sda_host_o,
        output sda_host_oe
    );
endinterface

// ### include/adc_rd_pkg.sv
// Constants shared by both ends of the two-wire conversion read link.
// Assumes a 10 MHz system clock on the controller end.
package adc_rd_pkg;
    // System clock period
    localparam int SYS_PERIOD_NS = 100;
    // Acquisition length before the input is sampled
    localparam int ACQ_NS = 600;
    localparam int ACQ_CYC = (ACQ_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
    // Conversion length of the behavioural converter
    localparam int CONV_CYC = 12;
    // Clock held high after the ninth rising edge
    localparam int STRETCH_NS = 2000;
    localparam int STRETCH_CYC = STRETCH_NS / SYS_PERIOD_NS;
    // Quarter of a link clock period, in system cycles
    localparam int QTR_CYC = 5;
    // Bus address of the converter
    localparam logic [6:0] DEV_ADDR = 7'h29;
    // High-speed master code, upper five bits; low three are don't care
    localparam logic [4:0] HS_CODE = 5'h01;
    // Conversion result width and word layout
    localparam int RES_BITS = 12;
    localparam int TAG_LSB = 12;
    localparam logic [3:0] CHAN_EN_RST = 4'hf;
    localparam logic [15:0] WORD_RST = 16'h0000;
    localparam logic [7:0] TMR_QTR = 8'(QTR_CYC - 1);
    localparam logic [7:0] TMR_STRETCH = 8'(STRETCH_CYC - 1);
    localparam logic [4:0] TMR_ACQ = 5'(ACQ_CYC - 1);
    localparam logic [4:0] TMR_CONV = 5'(CONV_CYC - 1);
endpackage

// ### rtl/adc_conv_slave.sv
// Converter end: answers read addresses and sequences conversions.
// Assumes the controller stretches the clock after each ninth rising edge that starts a conversion
// long enough for acquisition plus conversion to finish.
//
// Notes on behaviour
// - Each read returns two bytes, high first
// - Keep serving words while the reader acknowledges
// - Acknowledge own address with read bit set
// - First byte: two zeros, tag, four MSBs
// - Second byte: remaining bits, left aligned, zero padded
// - Power up, acquire at address ninth rising edge
// - Sample after acquisition time, convert while the clock is held high
// - Acknowledged second byte starts another conversion
// - Not-acknowledged second byte ends conversion activity
// - Reader not-acknowledges last word, acknowledges otherwise
// - Step to next enabled channel, else repeat
// - Stop condition puts converter into full shutdown
// - Start shut down; wake only on own address
// - Never acknowledge the high-speed master code
// - Repeated start, then address acknowledged in high speed
// - High-speed mode lasts until the next stop
// - Fast reader holds clock high after ninth edge
// - All four channels enabled after reset
// - Word: two zeros, two tag bits, data
`timescale 1ns/1ps
module adc_conv_slave (
    input wire logic sys_clk,
    input wire logic rstn,
    adc_link_if.dev link,
    input wire logic [11:0] sample_in,
    input wire logic cfg_wr,
    input wire logic [3:0] cfg_chan,
    output logic [1:0] chan_sel_q,
    output logic powered_q,
    output logic acquiring_q,
    output logic converting_q,
    output logic hs_mode_q,
    output logic [15:0] result_q
);
    typedef enum logic [1:0] {
        P_SHUT = 2'b00,
        P_ACQ = 2'b01,
        P_CONV = 2'b11,
        P_READY = 2'b10
    } pwr_e;

    typedef enum logic [1:0] {
        L_IDLE = 2'b00,
        L_ADDR = 2'b01,
        L_SEND = 2'b11
    } lnk_e;

    // Padding mask for the 10- and 8-bit variants
    localparam logic [11:0] DATA_MASK =
        12'(12'hfff << (12 - adc_rd_pkg::RES_BITS));

    // Link-side state, clocked by the link clock or by data line edges
    lnk_e lst_q;
    logic [3:0] bit_q;
    logic [7:0] rx_q;
    logic hi_q;
    logic start_tgl_q;
    logic stop_tgl_q;
    logic start_seen_q;
    logic req_tgl_q;
    logic hs_tgl_q;
    logic [15:0] word_hold_q;
    logic sda_oe_q;
    logic addr_hit;
    logic code_hit;
    logic [15:0] cur_word;
    logic [7:0] cur_byte;

    // System-side state
    pwr_e pst_q;
    logic [2:0] sync1_q;
    logic [2:0] sync2_q;
    logic [2:0] sync3_q;
    logic [11:0] smp1_q;
    logic [11:0] smp2_q;
    logic [4:0] tmr_q;
    logic [3:0] chan_en_q;
    logic fresh_q;
    logic [11:0] data_q;
    logic req_evt;
    logic stop_evt;
    logic hs_evt;

    assign addr_hit = (rx_q[7:1] == adc_rd_pkg::DEV_ADDR) && rx_q[0];
    assign code_hit = (rx_q[7:3] == adc_rd_pkg::HS_CODE);

    // Start and stop are data edges while the clock is high
    always_ff @(negedge link.sda_line or negedge rstn) begin
        if (!rstn) begin
            start_tgl_q <= 1'b0;
        end else if (link.scl) begin
            start_tgl_q <= ~start_tgl_q;
        end
    end

    always_ff @(posedge link.sda_line or negedge rstn) begin
        if (!rstn) begin
            stop_tgl_q <= 1'b0;
        end else if (link.scl) begin
            stop_tgl_q <= ~stop_tgl_q;
        end
    end

    // Receive side: a start always restarts the address phase, so a
    // transfer cut short by a stop leaves no stale state behind
    always_ff @(posedge link.scl or negedge rstn) begin
        if (!rstn) begin
            lst_q <= L_IDLE;
            bit_q <= 4'h0;
            rx_q <= 8'h00;
            hi_q <= 1'b1;
            start_seen_q <= 1'b0;
            req_tgl_q <= 1'b0;
            hs_tgl_q <= 1'b0;
        end else if (start_tgl_q != start_seen_q) begin
            start_seen_q <= start_tgl_q;
            lst_q <= L_ADDR;
            bit_q <= 4'h1;
            rx_q <= {7'h00, link.sda_line};
        end else begin
            case (lst_q)
                L_ADDR: begin
                    if (bit_q != 4'h8) begin
                        rx_q <= {rx_q[6:0], link.sda_line};
                        bit_q <= bit_q + 4'h1;
                    end else if (addr_hit) begin
                        // Ninth edge of own read address wakes it
                        req_tgl_q <= ~req_tgl_q;
                        lst_q <= L_SEND;
                        hi_q <= 1'b1;
                        bit_q <= 4'h0;
                    end else begin
                        // Master code: go quiet, note high speed
                        if (code_hit) begin
                            hs_tgl_q <= ~hs_tgl_q;
                        end
                        lst_q <= L_IDLE;
                    end
                end
                L_SEND: begin
                    if (bit_q != 4'h8) begin
                        bit_q <= bit_q + 4'h1;
                    end else begin
                        bit_q <= 4'h0;
                        if (link.sda_line) begin
                            lst_q <= L_IDLE;
                        end else if (hi_q) begin
                            hi_q <= 1'b0;
                        end else begin
                            // Acked second byte: next word follows
                            hi_q <= 1'b1;
                            req_tgl_q <= ~req_tgl_q;
                        end
                    end
                end
                default: begin
                    lst_q <= L_IDLE;
                end
            endcase
        end
    end

    // Word is quiet in the system domain from conversion end until the
    // next request, so the first-bit capture reads it settled
    assign cur_word = (hi_q && bit_q == 4'h0) ? result_q : word_hold_q;
    assign cur_byte = hi_q ? cur_word[15:8] : cur_word[7:0];

    // Drive side changes only while the clock is low
    always_ff @(negedge link.scl or negedge rstn) begin
        if (!rstn) begin
            sda_oe_q <= 1'b0;
            word_hold_q <= adc_rd_pkg::WORD_RST;
        end else if (lst_q == L_ADDR && bit_q == 4'h8) begin
            sda_oe_q <= addr_hit;
        end else if (lst_q == L_SEND && bit_q != 4'h8) begin
            if (hi_q && bit_q == 4'h0) begin
                word_hold_q <= result_q;
            end
            sda_oe_q <= ~cur_byte[3'(7 - bit_q)];
        end else begin
            sda_oe_q <= 1'b0;
        end
    end

    assign link.sda_dev_oe = sda_oe_q;
    assign link.sda_dev_o = 1'b0;

    // Two flops for each crossing toggle, a third for its edge
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            sync1_q <= 3'h0;
            sync2_q <= 3'h0;
            sync3_q <= 3'h0;
            smp1_q <= 12'h000;
            smp2_q <= 12'h000;
        end else begin
            sync1_q <= {hs_tgl_q, stop_tgl_q, req_tgl_q};
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            smp1_q <= sample_in;
            smp2_q <= smp1_q;
        end
    end

    assign req_evt = sync2_q[0] ^ sync3_q[0];
    assign stop_evt = sync2_q[1] ^ sync3_q[1];
    assign hs_evt = sync2_q[2] ^ sync3_q[2];

    // Next enabled channel in ascending order, wrapping round
    function automatic logic [1:0] pick_chan(input logic [3:0] en,
                                             input logic [1:0] last,
                                             input logic fresh);
        logic [1:0] r;
        logic [1:0] c;
        logic found;
        r = last;
        found = 1'b0;
        for (int i = 0; i < 4; i++) begin
            c = fresh ? 2'(i) : 2'(last + 2'(i) + 2'd1);
            if (!found && en[c]) begin
                r = c;
                found = 1'b1;
            end
        end
        return r;
    endfunction

    // Channel enables; all channels until the first write
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            chan_en_q <= adc_rd_pkg::CHAN_EN_RST;
        end else if (cfg_wr) begin
            chan_en_q <= cfg_chan;
        end
    end

    // High-speed flag; the master code wins over a stop in one cycle
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            hs_mode_q <= 1'b0;
        end else if (hs_evt) begin
            hs_mode_q <= 1'b1;
        end else if (stop_evt) begin
            hs_mode_q <= 1'b0;
        end
    end

    // Power sequencing; a request that meets a stop still converts
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pst_q <= P_SHUT;
            tmr_q <= 5'h00;
            fresh_q <= 1'b1;
            chan_sel_q <= 2'h0;
            data_q <= 12'h000;
            result_q <= adc_rd_pkg::WORD_RST;
            powered_q <= 1'b0;
            acquiring_q <= 1'b0;
            converting_q <= 1'b0;
        end else if (req_evt) begin
            pst_q <= P_ACQ;
            tmr_q <= adc_rd_pkg::TMR_ACQ;
            chan_sel_q <= pick_chan(chan_en_q, chan_sel_q,
                                    fresh_q);
            fresh_q <= 1'b0;
            powered_q <= 1'b1;
            acquiring_q <= 1'b1;
            converting_q <= 1'b0;
        end else if (stop_evt) begin
            pst_q <= P_SHUT;
            fresh_q <= 1'b1;
            powered_q <= 1'b0;
            acquiring_q <= 1'b0;
            converting_q <= 1'b0;
        end else begin
            case (pst_q)
                P_ACQ: begin
                    if (tmr_q == 5'h00) begin
                        // Sample taken; read waits on the held-high clock meanwhile
                        data_q <= smp2_q & DATA_MASK;
                        pst_q <= P_CONV;
                        tmr_q <= adc_rd_pkg::TMR_CONV;
                        acquiring_q <= 1'b0;
                        converting_q <= 1'b1;
                    end else begin
                        tmr_q <= tmr_q - 5'h01;
                    end
                end
                P_CONV: begin
                    if (tmr_q == 5'h00) begin
                        // Zeros, channel tag, left-aligned data
                        result_q <= {2'b00, chan_sel_q,
                                     data_q};
                        pst_q <= P_READY;
                        converting_q <= 1'b0;
                    end else begin
                        tmr_q <= tmr_q - 5'h01;
                    end
                end
                P_SHUT: begin
                    powered_q <= 1'b0;
                end
                default: begin
                    // Partly powered until a stop arrives
                    pst_q <= P_READY;
                end
            endcase
        end
    end
endmodule

// ### rtl/adc_read_master.sv
// Controller end: makes the link clock and reads result words.
// Assumes a single controller on the link and no clock stretching by
// the converter.
`timescale 1ns/1ps
module adc_read_master (
    input wire logic sys_clk,
    input wire logic rstn,
    adc_link_if.host link,
    input wire logic rd_go,
    input wire logic [7:0] rd_words,
    input wire logic hs_go,
    output logic [15:0] word_q,
    output logic word_valid_q,
    output logic busy_q,
    output logic nak_q,
    output logic done_q
);
    typedef enum logic [1:0] {
        H_IDLE = 2'b00,
        H_START = 2'b01,
        H_BYTE = 2'b11,
        H_STOP = 2'b10
    } hst_e;

    typedef enum logic [1:0] {
        K_CODE = 2'b00,
        K_ADDR = 2'b01,
        K_HI = 2'b11,
        K_LO = 2'b10
    } kind_e;

    hst_e st_q;
    kind_e kind_q;
    logic [1:0] phase_q;
    logic [7:0] tmr_q;
    logic [3:0] bit_q;
    logic [7:0] sh_q;
    logic [7:0] hi_q;
    logic [7:0] left_q;
    logic ack_q;
    logic scl_q;
    logic oe_q;
    logic sda1_q;
    logic sda2_q;
    logic tx;
    logic more;

    assign tx = (kind_q == K_CODE) || (kind_q == K_ADDR);
    assign more = (left_q != 8'h01);
    assign link.scl = scl_q;
    assign link.sda_host_oe = oe_q;
    assign link.sda_host_o = 1'b0;

    // Data line comes back through two flops
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            sda1_q <= 1'b1;
            sda2_q <= 1'b1;
        end else begin
            sda1_q <= link.sda_line;
            sda2_q <= sda1_q;
        end
    end

    // Bit engine: four timed phases per bit, clock low on entry
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            st_q <= H_IDLE;
            kind_q <= K_ADDR;
            phase_q <= 2'h0;
            tmr_q <= 8'h00;
            bit_q <= 4'h0;
            sh_q <= 8'h00;
            hi_q <= 8'h00;
            left_q <= 8'h00;
            ack_q <= 1'b1;
            scl_q <= 1'b1;
            oe_q <= 1'b0;
            word_q <= 16'h0000;
            word_valid_q <= 1'b0;
            busy_q <= 1'b0;
            nak_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            word_valid_q <= 1'b0;
            done_q <= 1'b0;
            if (st_q == H_IDLE) begin
                if (rd_go && rd_words != 8'h00) begin
                    busy_q <= 1'b1;
                    nak_q <= 1'b0;
                    left_q <= rd_words;
                    kind_q <= hs_go ? K_CODE : K_ADDR;
                    sh_q <= hs_go ? {adc_rd_pkg::HS_CODE, 3'h0}
                                  : {adc_rd_pkg::DEV_ADDR, 1'b1};
                    st_q <= H_START;
                    phase_q <= 2'h0;
                    tmr_q <= adc_rd_pkg::TMR_QTR;
                end
            end else if (tmr_q != 8'h00) begin
                tmr_q <= tmr_q - 8'h01;
            end else begin
                phase_q <= phase_q + 2'h1;
                tmr_q <= adc_rd_pkg::TMR_QTR;
                case (st_q)
                    H_START: begin
                        // Also serves as a repeated start
                        case (phase_q)
                            2'h0: oe_q <= 1'b0;
                            2'h1: scl_q <= 1'b1;
                            2'h2: oe_q <= 1'b1;
                            default: begin
                                scl_q <= 1'b0;
                                st_q <= H_BYTE;
                                bit_q <= 4'h0;
                            end
                        endcase
                    end
                    H_BYTE: begin
                        case (phase_q)
                            2'h0: begin
                                if (bit_q != 4'h8) begin
                                    oe_q <= tx && !sh_q[7];
                                end else begin
                                    // Ack every high byte; ack a low byte only when another word is due
                                    oe_q <= (kind_q == K_HI) ||
                                            (kind_q == K_LO && more);
                                end
                            end
                            2'h1: begin
                                scl_q <= 1'b1;
                                // Held high while the converter runs
                                if (bit_q == 4'h8 && (kind_q == K_ADDR ||
                                    (kind_q == K_LO && more))) begin
                                    tmr_q <= adc_rd_pkg::TMR_STRETCH;
                                end
                            end
                            2'h2: begin
                                if (bit_q != 4'h8) begin
                                    sh_q <= {sh_q[6:0], sda2_q};
                                end else begin
                                    ack_q <= sda2_q;
                                end
                            end
                            default: begin
                                scl_q <= 1'b0;
                                if (bit_q != 4'h8) begin
                                    bit_q <= bit_q + 4'h1;
                                end else begin
                                    bit_q <= 4'h0;
                                    case (kind_q)
                                        K_CODE: begin
                                            kind_q <= K_ADDR;
                                            sh_q <= {adc_rd_pkg::DEV_ADDR,
                                                     1'b1};
                                            st_q <= H_START;
                                        end
                                        K_ADDR: begin
                                            kind_q <= K_HI;
                                            nak_q <= ack_q;
                                            if (ack_q) begin
                                                st_q <= H_STOP;
                                            end
                                        end
                                        K_HI: begin
                                            hi_q <= sh_q;
                                            kind_q <= K_LO;
                                        end
                                        default: begin
                                            word_q <= {hi_q, sh_q};
                                            word_valid_q <= 1'b1;
                                            left_q <= left_q - 8'h01;
                                            kind_q <= K_HI;
                                            if (!more) begin
                                                st_q <= H_STOP;
                                            end
                                        end
                                    endcase
                                end
                            end
                        endcase
                    end
                    default: begin
                        // Stop: data rises while the clock is high
                        case (phase_q)
                            2'h0: oe_q <= 1'b1;
                            2'h1: scl_q <= 1'b1;
                            2'h2: oe_q <= 1'b0;
                            default: begin
                                st_q <= H_IDLE;
                                busy_q <= 1'b0;
                                done_q <= 1'b1;
                            end
                        endcase
                    end
                endcase
            end
        end
    end
endmodule

// ### tb/adc_link_props.sv
// Checker for the conversion read link, sampled on the system clock.
// Assumes both ends share sys_clk and rstn; host makes the link clock.
`timescale 1ns/1ps
module adc_link_props (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic scl,
    input wire logic sda_line,
    input wire logic sda_dev_oe,
    input wire logic powered_q,
    input wire logic acquiring_q,
    input wire logic converting_q,
    input wire logic hs_mode_q,
    input wire logic [1:0] chan_sel_q,
    input wire logic [15:0] result_q
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // Stop: data rises while the clock stays high
    sequence stop_s;
        scl && $past(scl) && $rose(sda_line);
    endsequence
    // Acquisition of six cycles hands over to conversion
    sequence acq_s;
        acquiring_q [*6] ##1 (!acquiring_q && converting_q);
    endsequence
    // Conversion holds twelve cycles, then drops
    sequence conv_s;
        converting_q [*6] ##1 converting_q [*6] ##1 !converting_q;
    endsequence
    dev_sda_a: assert property ($changed(sda_dev_oe) |-> !scl)
        else $error("converter moved data while clock high");
    wake_ack_a: assert property ($rose(powered_q) |->
        scl && sda_dev_oe)
        else $error("converter woke outside its own acknowledge");
    acq_len_a: assert property ($rose(acquiring_q) |-> acq_s)
        else $error("acquisition length wrong");
    conv_len_a: assert property ($rose(converting_q) |-> conv_s)
        else $error("conversion length wrong");
    acq_stretch_a: assert property ($rose(acquiring_q) |-> scl [*8])
        else $error("clock not held high during acquisition");
    stop_off_a: assert property (stop_s |-> ##[1:6] !powered_q)
        else $error("no shutdown after stop");
    hs_exit_a: assert property (stop_s |-> ##[1:6] !hs_mode_q)
        else $error("high speed kept after stop");
    lead_zero_a: assert property (result_q[15:14] == 2'b00)
        else $error("leading bits of result not zero");
    tag_match_a: assert property ($changed(result_q) |->
        result_q[13:12] == chan_sel_q)
        else $error("result tag differs from converted channel");
endmodule

// ### tb/i2c_adc_read_conversion_ctrl_tb.sv
// Testbench joining the read controller and the converter on one link.
// Assumes both ends run on sys_clk; the host divides it for the link clock.
`timescale 1ns/1ps
module i2c_adc_read_conversion_ctrl_tb;
    logic sys_clk = 1'b0;
    // Left unknown so the time-zero assertion is a real falling edge
    logic rstn;
    logic rd_go = 1'b0;
    logic hs_go = 1'b0;
    logic cfg_wr = 1'b0;
    logic [7:0] rd_words = 8'h00;
    logic [11:0] sample_in = 12'h000;
    logic [3:0] cfg_chan = 4'hf;
    logic [1:0] chan_sel_q;
    logic powered_q, acquiring_q, converting_q, hs_mode_q;
    logic word_valid_q, busy_q, nak_q, done_q;
    logic [15:0] result_q, word_q;
    int mismatches = 0;
    int cmp_count = 0;
    int convs = 0;
    adc_link_if link();
    adc_conv_slave u_adc_conv_slave (.sys_clk(sys_clk), .rstn(rstn),
        .link(link), .sample_in(sample_in), .cfg_wr(cfg_wr),
        .cfg_chan(cfg_chan), .chan_sel_q(chan_sel_q), .powered_q(powered_q),
        .acquiring_q(acquiring_q), .converting_q(converting_q),
        .hs_mode_q(hs_mode_q), .result_q(result_q));
    adc_read_master u_adc_read_master (.sys_clk(sys_clk), .rstn(rstn),
        .link(link), .rd_go(rd_go), .rd_words(rd_words), .hs_go(hs_go),
        .word_q(word_q), .word_valid_q(word_valid_q), .busy_q(busy_q),
        .nak_q(nak_q), .done_q(done_q));
    adc_link_props u_adc_link_props (.sys_clk(sys_clk), .rstn(rstn),
        .scl(link.scl), .sda_line(link.sda_line),
        .sda_dev_oe(link.sda_dev_oe), .powered_q(powered_q),
        .acquiring_q(acquiring_q), .converting_q(converting_q),
        .hs_mode_q(hs_mode_q), .chan_sel_q(chan_sel_q), .result_q(result_q));
    // 10 MHz system clock
    always #50 sys_clk = ~sys_clk;
    // Conversions started over the whole run; only this process writes it
    always @(posedge converting_q) convs++;
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        if (mismatches == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // One transfer of n words; chans packs the expected tag of each word
    task automatic do_read(input logic [7:0] n, input logic hs,
                           input logic [7:0] chans, input logic [11:0] s);
        int k;
        int t;
        int c0;
        k = 0;
        c0 = convs;
        @(posedge sys_clk);
        rd_words <= n;
        hs_go <= hs;
        sample_in <= s;
        rd_go <= 1'b1;
        @(posedge sys_clk);
        rd_go <= 1'b0;
        // Bounded wait of 8000 cycles; a hang beyond it fails the done check below
        for (t = 0; t < 8000 && done_q !== 1'b1; t++) begin
            @(negedge sys_clk);
            if (word_valid_q === 1'b1) begin
                check(word_q, {2'b00, chans[2*k +: 2], s});
                check(16'(hs_mode_q), 16'(hs));
                check(16'(busy_q), 16'h0001);
                k++;
            end
        end
        // A wait that ran out shows here as a missing done pulse
        check(16'(done_q), 16'h0001);
        check(16'(nak_q), 16'h0000);
        check(16'(k), 16'(n));
        repeat (6) @(negedge sys_clk);
        check(16'(convs - c0), 16'(n));
        check(16'(powered_q), 16'h0000);
        check(16'(hs_mode_q), 16'h0000);
        check(16'(busy_q), 16'h0000);
    endtask
    // Main sequence: default channels, single channel, pair, high speed
    initial begin
        // Flops clocked by link edges only reset on a falling rstn
        rstn <= 1'b0;
        repeat (3) @(posedge sys_clk);
        rstn <= 1'b1;
        @(negedge sys_clk);
        check(16'(powered_q), 16'h0000);
        do_read(8'h03, 1'b0, 8'h24, 12'ha5c);
        @(posedge sys_clk);
        cfg_chan <= 4'h4;
        cfg_wr <= 1'b1;
        @(posedge sys_clk);
        cfg_wr <= 1'b0;
        do_read(8'h02, 1'b0, 8'h0a, 12'h3f0);
        @(posedge sys_clk);
        cfg_chan <= 4'ha;
        cfg_wr <= 1'b1;
        @(posedge sys_clk);
        cfg_wr <= 1'b0;
        do_read(8'h03, 1'b0, 8'h1d, 12'hfff);
        do_read(8'h01, 1'b1, 8'h01, 12'h001);
        summarize();
    end
    // Watchdog well beyond the expected few thousand cycles
    initial begin
        repeat (40000) @(posedge sys_clk);
        mismatches++;
        summarize();
    end
endmodule
